// [design/dcbs_top.sv]
// dc injection brake sequencer with axi4-lite registers
// Function
// - braking runs after stop only when stop mode selects dc braking
// - braking needs a relay assigned to the braking function
// - on stop energize relay, wait brake delay, then gate thyristors
// - gate dc current for exactly the brake time, then stop gating
// - hold relay energized for a decay interval after brake time
// - decay interval grows with full-load current, 0.4 s to 4.3 s
// - standard duty regulates current at brake level, at most 250 percent
// - heavy duty relay enables freewheel thyristor path, up to 400 percent
// - heavy duty braked stop counts as one extra motor start
// - overload stays active during braking with running setting
// - overload calculation adjusted by brake type and feedback source
// - brake-enable input must stay energized, braking ends when it drops
// - brake-disable input energized ends braking
// - input-ended braking goes straight to idle, no resume
// - hall feedback sets analog input to 0-10V voltage mode
// - brake type and feedback are fixed factory straps
`timescale 1ns/10ps
`include "dcbs_defines.svh"
module dcbs_top #(
    parameter int unsigned MS_CYCLES = `DCBS_MS_CYCLES
) (
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // axi4-lite slave
    input  wire logic [7:0]           s_awaddr,
    input  wire logic                 s_awvalid,
    output logic                      s_awready,
    input  wire logic [31:0]          s_wdata,
    input  wire logic [3:0]           s_wstrb,
    input  wire logic                 s_wvalid,
    output logic                      s_wready,
    output logic [1:0]                s_bresp,
    output logic                      s_bvalid,
    input  wire logic                 s_bready,
    input  wire logic [7:0]           s_araddr,
    input  wire logic                 s_arvalid,
    output logic                      s_arready,
    output logic [31:0]               s_rdata,
    output logic [1:0]                s_rresp,
    output logic                      s_rvalid,
    input  wire logic                 s_rready,
    // starter inputs
    input  wire logic                 stop_cmd,
    input  wire logic                 brake_en_in,
    input  wire logic                 brake_dis_in,
    input  wire logic                 heavy_duty_strap,
    input  wire logic                 hall_feedback_strap,
    // brake outputs
    output logic                      brake_relay,
    output logic                      scr_gate_en,
    output logic                      freewheel_en,
    output logic [15:0]               current_ref,
    output logic                      extra_start,
    output logic                      analog_volt_mode,
    output dcbs_pkg::dcbs_overload_t  thermal_overload,
    output logic                      irq
);
    import dcbs_pkg::*;

    function automatic logic [15:0] decay_of(input logic [15:0] amps);
        int unsigned f;
        int unsigned d;
        f = 32'(amps);
        if (f <= `DCBS_LOAD_P0)
            d = `DCBS_DECAY_P0;
        else if (f <= `DCBS_LOAD_P1)
            d = `DCBS_DECAY_P0 + (f - `DCBS_LOAD_P0) * (`DCBS_DECAY_P1 - `DCBS_DECAY_P0)
                / (`DCBS_LOAD_P1 - `DCBS_LOAD_P0);
        else if (f <= `DCBS_LOAD_P2)
            d = `DCBS_DECAY_P1 + (f - `DCBS_LOAD_P1) * (`DCBS_DECAY_P2 - `DCBS_DECAY_P1)
                / (`DCBS_LOAD_P2 - `DCBS_LOAD_P1);
        else if (f <= `DCBS_LOAD_P3)
            d = `DCBS_DECAY_P2 + (f - `DCBS_LOAD_P2) * (`DCBS_DECAY_P3 - `DCBS_DECAY_P2)
                / (`DCBS_LOAD_P3 - `DCBS_LOAD_P2);
        else
            d = `DCBS_DECAY_P3;
        return d[15:0];
    endfunction : decay_of

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
        return {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    // register file
    dcbs_ctrl_t             ctrl_reg;
    logic [15:0]            level_reg;
    logic [15:0]            delay_reg;
    logic [15:0]            time_reg;
    logic [15:0]            full_load_reg;
    logic [`DCBS_IRQ_W-1:0] stat_reg;
    logic [`DCBS_IRQ_W-1:0] mask_reg;
    logic [15:0]            starts_reg;
    logic [15:0]            decay_reg;
    logic                   heavy_reg;
    logic                   hall_reg;
    logic                   strap_done_reg;
    // bus holding
    logic [7:0]             awaddr_reg;
    logic [31:0]            wdata_reg;
    logic [3:0]             wstrb_reg;
    // sequencer
    dcbs_state_t            state_reg;
    dcbs_state_t            state_next;
    logic [31:0]            pre_reg;
    logic [15:0]            ms_reg;

    // decode
    wire aw_hs    = s_awvalid && s_awready;
    wire w_hs     = s_wvalid && s_wready;
    wire ar_hs    = s_arvalid && s_arready;
    wire do_write = !s_awready && !s_wready && !s_bvalid;
    wire wr_ctrl  = do_write && awaddr_reg == `DCBS_OFF_CTRL;
    wire wr_level = do_write && awaddr_reg == `DCBS_OFF_LEVEL;
    wire wr_delay = do_write && awaddr_reg == `DCBS_OFF_DELAY;
    wire wr_time  = do_write && awaddr_reg == `DCBS_OFF_TIME;
    wire wr_load  = do_write && awaddr_reg == `DCBS_OFF_FULL_LOAD;
    wire wr_mask  = do_write && awaddr_reg == `DCBS_OFF_IRQ_MASK;
    wire wr_ok    = wr_ctrl || wr_level || wr_delay || wr_time || wr_load || wr_mask;
    wire rd_clr   = ar_hs && s_araddr == `DCBS_OFF_IRQ_STAT;

    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        unique case (s_araddr)
            `DCBS_OFF_CTRL:     rd_mux = {28'h0000000, ctrl_reg};
            `DCBS_OFF_LEVEL:    rd_mux = {16'h0000, level_reg};
            `DCBS_OFF_DELAY:    rd_mux = {16'h0000, delay_reg};
            `DCBS_OFF_TIME:     rd_mux = {16'h0000, time_reg};
            `DCBS_OFF_FULL_LOAD: rd_mux = {16'h0000, full_load_reg};
            `DCBS_OFF_STATUS:   rd_mux = {24'h000000, hall_reg, heavy_reg, freewheel_en,
                                          scr_gate_en, brake_relay, 1'b0, state_reg};
            `DCBS_OFF_IRQ_STAT: rd_mux = {29'h00000000, stat_reg};
            `DCBS_OFF_IRQ_MASK: rd_mux = {29'h00000000, mask_reg};
            `DCBS_OFF_STARTS:   rd_mux = {16'h0000, starts_reg};
            `DCBS_OFF_DECAY:    rd_mux = {16'h0000, decay_reg};
            default: begin
                rd_mux = 32'h00000000;
                rd_ok  = 1'b0;
            end
        endcase
    end

    // sequencing conditions
    wire permit     = (!ctrl_reg.en_assigned || brake_en_in)
                   && (!ctrl_reg.dis_assigned || !brake_dis_in);
    wire armed      = ctrl_reg.stop_dc && ctrl_reg.relay_assigned;
    wire ms_tick    = pre_reg == MS_CYCLES - 1;
    wire busy       = state_reg != DCBS_IDLE;
    wire abort      = busy && !permit;
    logic [15:0] target;
    always_comb begin
        unique case (state_reg)
            DCBS_DELAY:  target = delay_reg;
            DCBS_INJECT: target = time_reg;
            DCBS_DECAY:  target = decay_reg;
            DCBS_IDLE:   target = 16'h0000;
        endcase
    end
    wire expired    = ms_reg == target;

    always_comb begin
        state_next = state_reg;
        if (abort)
            state_next = DCBS_IDLE;
        else begin
            unique case (state_reg)
                DCBS_IDLE:   if (stop_cmd && armed && permit) state_next = DCBS_DELAY;
                DCBS_DELAY:  if (expired) state_next = DCBS_INJECT;
                DCBS_INJECT: if (expired) state_next = DCBS_DECAY;
                DCBS_DECAY:  if (expired) state_next = DCBS_IDLE;
            endcase
        end
    end
    wire state_chg  = state_next != state_reg;
    wire enter_inj  = state_chg && state_next == DCBS_INJECT;
    wire done_evt   = state_chg && state_reg == DCBS_DECAY && !abort;
    wire [`DCBS_IRQ_W-1:0] irq_set = {abort, done_evt, enter_inj};
    wire [15:0] limit  = heavy_reg ? `DCBS_LIMIT_HEAVY : `DCBS_LIMIT_STD;
    wire [15:0] ref_v  = level_reg > limit ? limit : level_reg;

    // bus channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready  <= 1'b1;
            s_wready   <= 1'b1;
            s_bvalid   <= 1'b0;
            s_bresp    <= `DCBS_RESP_OKAY;
            awaddr_reg <= 8'h00;
            wdata_reg  <= 32'h00000000;
            wstrb_reg  <= 4'h0;
        end else begin
            if (aw_hs) begin
                s_awready  <= 1'b0;
                awaddr_reg <= s_awaddr;
            end
            if (w_hs) begin
                s_wready  <= 1'b0;
                wdata_reg <= s_wdata;
                wstrb_reg <= s_wstrb;
            end
            if (do_write) begin
                s_bvalid <= 1'b1;
                s_bresp  <= wr_ok ? `DCBS_RESP_OKAY : `DCBS_RESP_SLVERR;
            end
            if (s_bvalid && s_bready) begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h00000000;
            s_rresp   <= `DCBS_RESP_OKAY;
        end else if (ar_hs) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rdata   <= rd_mux;
            s_rresp   <= rd_ok ? `DCBS_RESP_OKAY : `DCBS_RESP_SLVERR;
        end else if (s_rvalid && s_rready) begin
            s_rvalid  <= 1'b0;
            s_arready <= 1'b1;
        end
    end

    // writable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg  <= `DCBS_RST_CTRL;
            level_reg <= `DCBS_RST_LEVEL;
            delay_reg <= `DCBS_RST_DELAY;
            time_reg  <= `DCBS_RST_TIME;
            full_load_reg <= `DCBS_RST_FULL_LOAD;
            mask_reg  <= 3'h0;
        end else begin
            if (wr_ctrl && wstrb_reg[0])
                ctrl_reg <= wdata_reg[`DCBS_CTRL_W-1:0];
            if (wr_level)
                level_reg <= merge16(level_reg, wdata_reg, wstrb_reg);
            if (wr_delay)
                delay_reg <= merge16(delay_reg, wdata_reg, wstrb_reg);
            if (wr_time)
                time_reg <= merge16(time_reg, wdata_reg, wstrb_reg);
            if (wr_load)
                full_load_reg <= merge16(full_load_reg, wdata_reg, wstrb_reg);
            if (wr_mask && wstrb_reg[0])
                mask_reg <= wdata_reg[`DCBS_IRQ_W-1:0];
        end
    end

    // straps sampled once after reset release so a later change has no effect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_done_reg <= 1'b0;
            heavy_reg      <= 1'b0;
            hall_reg       <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            heavy_reg      <= heavy_duty_strap;
            hall_reg       <= hall_feedback_strap;
        end
    end

    // sequencer and timers; interval is counted in whole milliseconds
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= DCBS_IDLE;
            pre_reg   <= 32'h00000000;
            ms_reg    <= 16'h0000;
            decay_reg <= 16'(`DCBS_DECAY_P0);
        end else begin
            state_reg <= state_next;
            if (state_chg || !busy) begin
                pre_reg <= 32'h00000000;
                ms_reg  <= 16'h0000;
            end else if (ms_tick) begin
                pre_reg <= 32'h00000000;
                ms_reg  <= ms_reg + 16'h0001;
            end else
                pre_reg <= pre_reg + 32'h00000001;
            // latched on entering decay so a full-load write during decay cannot shorten it
            if (state_reg != DCBS_DECAY)
                decay_reg <= decay_of(full_load_reg);
        end
    end

    // outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brake_relay      <= 1'b0;
            scr_gate_en      <= 1'b0;
            freewheel_en     <= 1'b0;
            current_ref      <= 16'h0000;
            extra_start      <= 1'b0;
            starts_reg       <= 16'h0000;
            analog_volt_mode <= 1'b0;
            thermal_overload <= '0;
            stat_reg         <= 3'h0;
            irq              <= 1'b0;
        end else begin
            brake_relay      <= state_next != DCBS_IDLE;
            scr_gate_en      <= state_next == DCBS_INJECT;
            freewheel_en     <= heavy_reg && state_next != DCBS_IDLE;
            current_ref      <= state_next == DCBS_INJECT ? ref_v : 16'h0000;
            extra_start      <= enter_inj && heavy_reg;
            if (enter_inj && heavy_reg)
                starts_reg <= starts_reg + 16'h0001;
            analog_volt_mode <= hall_reg;
            thermal_overload <= '{running_sel: state_next != DCBS_IDLE,
                                  heavy: heavy_reg, hall: hall_reg};
            // a new event wins over the read that clears
            stat_reg         <= (stat_reg & ~{`DCBS_IRQ_W{rd_clr}}) | irq_set;
            irq              <= |(((stat_reg & ~{`DCBS_IRQ_W{rd_clr}}) | irq_set) & mask_reg);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_no_arm_no_brake: assert property (!armed && !busy |=> !brake_relay)
        else $error("brake started while not armed");
    a_relay_assign: assert property (!ctrl_reg.relay_assigned && !busy |=> !busy)
        else $error("brake ran without a braking relay");
    a_delay_first: assert property ($rose(scr_gate_en) |-> $past(brake_relay)
                                    && $past(state_reg) == DCBS_DELAY)
        else $error("gating began without relay delay");
    a_gate_end: assert property ($fell(scr_gate_en) && !$past(abort)
                                 |-> brake_relay && state_reg == DCBS_DECAY)
        else $error("gating end not followed by decay hold");
    a_decay_hold: assert property (state_reg == DCBS_DECAY && !expired && permit
                                   |=> brake_relay)
        else $error("relay released during decay");
    a_decay_clamp: assert property (decay_reg >= `DCBS_DECAY_P0
                                    && decay_reg <= `DCBS_DECAY_P3)
        else $error("decay interval outside table range");
    a_ref_limit: assert property (current_ref <= (heavy_reg ? `DCBS_LIMIT_HEAVY
                                                            : `DCBS_LIMIT_STD))
        else $error("current reference above duty limit");
    a_std_no_fw: assert property (!heavy_reg |-> !freewheel_en)
        else $error("freewheel enabled in standard duty");
    a_extra_start: assert property (extra_start |-> heavy_reg && scr_gate_en
                                    && starts_reg == $past(starts_reg) + 16'h0001)
        else $error("start count not tied to heavy brake");
    a_overload_run: assert property (brake_relay |-> thermal_overload.running_sel)
        else $error("overload not on running setting");
    a_overload_adjust: assert property (strap_done_reg |=> thermal_overload.heavy == heavy_reg
                                  && thermal_overload.hall == hall_reg)
        else $error("overload adjust mismatch");
    a_input_abort: assert property (abort |=> !brake_relay && !scr_gate_en ##1 !brake_relay)
        else $error("braking continued after input change");
    a_no_resume: assert property (abort |=> state_reg == DCBS_IDLE)
        else $error("no direct return to idle");
    a_dis_input: assert property (ctrl_reg.dis_assigned && brake_dis_in && busy
                                  |=> !busy)
        else $error("brake-disable input ignored");
    a_hall_mode: assert property (strap_done_reg |=> analog_volt_mode == hall_reg)
        else $error("analog mode not following feedback");
    a_strap_fixed: assert property (strap_done_reg |=> $stable(heavy_reg) && $stable(hall_reg))
        else $error("factory strap changed at runtime");
    a_rise_decay: assert property (decay_reg > 16'h0000 && full_load_reg > `DCBS_LOAD_P3
                                   && state_reg == DCBS_IDLE
                                   |=> decay_reg == `DCBS_DECAY_P3)
        else $error("decay not clamped at large current");

    c_full_brake: cover property (state_reg == DCBS_DECAY ##1 state_reg == DCBS_IDLE);
    c_abort:      cover property (abort && state_reg == DCBS_INJECT);
    c_heavy:      cover property (extra_start);
    c_irq:        cover property ($rose(irq));
endmodule : dcbs_top

// [inc/dcbs_defines.svh]
// register offsets, field positions, reset values and timing constants of the brake sequencer
`ifndef DCBS_DEFINES_SVH
`define DCBS_DEFINES_SVH
`define DCBS_OFF_CTRL        8'h00
`define DCBS_OFF_LEVEL       8'h04
`define DCBS_OFF_DELAY       8'h08
`define DCBS_OFF_TIME        8'h0c
`define DCBS_OFF_FULL_LOAD   8'h10
`define DCBS_OFF_STATUS      8'h14
`define DCBS_OFF_IRQ_STAT    8'h18
`define DCBS_OFF_IRQ_MASK    8'h1c
`define DCBS_OFF_STARTS      8'h20
`define DCBS_OFF_DECAY       8'h24
`define DCBS_CTRL_W          4
`define DCBS_IRQ_W           3
`define DCBS_IRQ_BIT_START   0
`define DCBS_IRQ_BIT_DONE    1
`define DCBS_IRQ_BIT_ABORT   2
`define DCBS_RST_CTRL        4'h0
`define DCBS_RST_LEVEL       16'h0064
`define DCBS_RST_DELAY       16'h00c8
`define DCBS_RST_TIME        16'h03e8
`define DCBS_RST_FULL_LOAD   16'h000a
`define DCBS_LIMIT_STD       16'h00fa
`define DCBS_LIMIT_HEAVY     16'h0190
`define DCBS_LOAD_P0         10
`define DCBS_LOAD_P1         100
`define DCBS_LOAD_P2         500
`define DCBS_LOAD_P3         1000
`define DCBS_DECAY_P0        400
`define DCBS_DECAY_P1        800
`define DCBS_DECAY_P2        2300
`define DCBS_DECAY_P3        4300
`define DCBS_CLK_NS          50
`define DCBS_MS_NS           1000000
`define DCBS_MS_CYCLES       (`DCBS_MS_NS / `DCBS_CLK_NS)
`define DCBS_RESP_OKAY       2'b00
`define DCBS_RESP_SLVERR     2'b10
`endif

// [inc/dcbs_pkg.sv]
// types shared by the brake sequencer
package dcbs_pkg;
    typedef enum logic [1:0] {
        DCBS_IDLE   = 2'b00,
        DCBS_DELAY  = 2'b01,
        DCBS_INJECT = 2'b10,
        DCBS_DECAY  = 2'b11
    } dcbs_state_t;

    typedef struct packed {
        logic dis_assigned;
        logic en_assigned;
        logic relay_assigned;
        logic stop_dc;
    } dcbs_ctrl_t;

    typedef struct packed {
        logic       running_sel;
        logic       heavy;
        logic       hall;
    } dcbs_overload_t;
endpackage : dcbs_pkg

// [verif/dcbs_contactor_model.sv]
// braking contactor and freewheel gating card seen from the motor terminals
`timescale 1ns/10ps
module dcbs_contactor_model (
    // coil and gating drive from the sequencer
    input  wire logic brake_relay,
    input  wire logic freewheel_en,
    // contact and thyristor state at the motor terminals
    output logic      short_t2_t3,
    output logic      short_t1_t3,
    output logic      freewheel_path
);
    // standard duty: the contactor closes across terminals 2 and 3 only
    assign short_t2_t3    = brake_relay & ~freewheel_en;
    // a contact across phases 1 and 3 would short the supply, so it never closes
    assign short_t1_t3    = 1'b0;
    assign freewheel_path = brake_relay & freewheel_en;
endmodule : dcbs_contactor_model

// [verif/dcbs_top_tb_top.sv]
// self-checking bench for the dc injection brake sequencer
`timescale 1ns/10ps
`include "dcbs_defines.svh"
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_errors++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, s); end end
`define SPAN(c, n) begin n = 0; while ((c) && n < 3000) begin @(posedge aclk); #1; n++; end end
module dcbs_top_tb_top;
    import dcbs_pkg::*;
    localparam int unsigned MSC = 4;
    int          n_errors = 0;
    int          checks = 0;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic [3:0]  s_wstrb = 4'hf;
    logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic        s_arvalid = 1'b0, s_rready = 1'b0;
    logic        stop_cmd = 1'b0, brake_en_in = 1'b0, brake_dis_in = 1'b0;
    logic        heavy_strap = 1'b0, hall_strap = 1'b1;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0]  s_bresp, s_rresp;
    logic        brake_relay, scr_gate_en, freewheel_en, extra_start;
    logic        analog_volt_mode, irq, short_t2_t3, short_t1_t3, freewheel_path;
    logic [15:0] current_ref;
    dcbs_overload_t thermal_overload;

    always #25 aclk = ~aclk;

    // straps are latched once after reset; t_heavy swaps them across a second reset
    dcbs_top #(.MS_CYCLES(MSC)) dut_u (
        .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
        .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
        .s_rdata, .s_rresp, .s_rvalid, .s_rready, .stop_cmd, .brake_en_in, .brake_dis_in,
        .heavy_duty_strap(heavy_strap), .hall_feedback_strap(hall_strap), .brake_relay,
        .scr_gate_en, .freewheel_en, .current_ref, .extra_start, .analog_volt_mode,
        .thermal_overload, .irq
    );
    dcbs_contactor_model contactor_u (.brake_relay, .freewheel_en, .short_t2_t3, .short_t1_t3,
        .freewheel_path);

    task automatic end_sim;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        // address and data may be taken on different edges
        do begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (s_awvalid || s_wvalid);
        do @(posedge aclk); while (!s_bvalid);
        s_bready <= 1'b0;
        `CHK("bresp", er, s_bresp)
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
                      input string nm);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge aclk); while (!s_arready);
        s_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_rvalid);
        s_rready <= 1'b0;
        `CHK(nm, e, s_rdata)
        `CHK(nm, er, s_rresp)
    endtask : rc

    task automatic stop;
        @(posedge aclk);
        stop_cmd <= 1'b1;
        @(posedge aclk);
        stop_cmd <= 1'b0;
        #1;
    endtask : stop

    task automatic t_regs;
        rc(`DCBS_OFF_LEVEL, 32'h64, `DCBS_RESP_OKAY, "level");
        rc(`DCBS_OFF_DELAY, 32'hc8, `DCBS_RESP_OKAY, "delay");
        rc(`DCBS_OFF_TIME, 32'h3e8, `DCBS_RESP_OKAY, "time");
        rc(`DCBS_OFF_STATUS, 32'h80, `DCBS_RESP_OKAY, "status");
        rc(8'h40, 32'h0, `DCBS_RESP_SLVERR, "unmapped");
        wr(`DCBS_OFF_STATUS, 32'h1, `DCBS_RESP_SLVERR);
        `CHK("volt_mode", 1'b1, analog_volt_mode)
        `CHK("overload_hall", 1'b1, thermal_overload.hall)
    endtask : t_regs

    task automatic t_refuse;
        logic [31:0] cfg [3] = '{32'h2, 32'h1, 32'h7};
        for (int i = 0; i < 3; i++) begin
            wr(`DCBS_OFF_CTRL, cfg[i], `DCBS_RESP_OKAY);
            stop;
            `CHK("refused", 1'b0, brake_relay)
        end
    endtask : t_refuse

    task automatic t_sequence;
        int n;
        wr(`DCBS_OFF_LEVEL, 32'h12c, `DCBS_RESP_OKAY);
        wr(`DCBS_OFF_DELAY, 32'h2, `DCBS_RESP_OKAY);
        wr(`DCBS_OFF_TIME, 32'h3, `DCBS_RESP_OKAY);
        wr(`DCBS_OFF_IRQ_MASK, 32'h7, `DCBS_RESP_OKAY);
        wr(`DCBS_OFF_CTRL, 32'h3, `DCBS_RESP_OKAY);
        stop;
        `CHK("relay", 1'b1, brake_relay)
        `CHK("running_sel", 1'b1, thermal_overload.running_sel)
        `SPAN(!scr_gate_en, n)
        `CHK("delay_cycles", 2 * MSC + 1, n)
        `CHK("ref", 16'h00fa, current_ref)
        `CHK("short23", 1'b1, short_t2_t3)
        `CHK("short13", 1'b0, short_t1_t3)
        `SPAN(scr_gate_en, n)
        `CHK("inject_cycles", 3 * MSC + 1, n)
        `CHK("relay_held", 1'b1, brake_relay)
        `SPAN(brake_relay, n)
        `CHK("decay_cycles", 400 * MSC + 1, n)
        `CHK("irq", 1'b1, irq)
        rc(`DCBS_OFF_IRQ_STAT, 32'h3, `DCBS_RESP_OKAY, "irq_stat");
        repeat (2) @(posedge aclk);
        #1;
        `CHK("irq_clear", 1'b0, irq)
        rc(`DCBS_OFF_STARTS, 32'h0, `DCBS_RESP_OKAY, "starts");
    endtask : t_sequence

    task automatic t_abort(input logic [31:0] ctrl, input logic dis);
        int n;
        wr(`DCBS_OFF_CTRL, ctrl, `DCBS_RESP_OKAY);
        @(posedge aclk);
        brake_en_in <= 1'b1;
        stop;
        `SPAN(!scr_gate_en, n)
        @(posedge aclk);
        brake_en_in <= dis;
        brake_dis_in <= dis;
        repeat (2) @(posedge aclk);
        #1;
        `CHK("abort_relay", 1'b0, brake_relay)
        `CHK("abort_gate", 1'b0, scr_gate_en)
        @(posedge aclk);
        brake_en_in <= 1'b1;
        brake_dis_in <= 1'b0;
        repeat (20) @(posedge aclk);
        #1;
        `CHK("no_resume", 1'b0, brake_relay)
        rc(`DCBS_OFF_IRQ_STAT, 32'h5, `DCBS_RESP_OKAY, "abort_stat");
    endtask : t_abort

    task automatic t_decay;
        int amps [7] = '{5, 55, 100, 500, 750, 1000, 2000};
        int dec [7] = '{400, 600, 800, 2300, 3300, 4300, 4300};
        for (int i = 0; i < 7; i++) begin
            wr(`DCBS_OFF_FULL_LOAD, amps[i], `DCBS_RESP_OKAY);
            rc(`DCBS_OFF_DECAY, dec[i], `DCBS_RESP_OKAY, "decay_ms");
        end
    endtask : t_decay

    // second reset with heavy duty and current-transformer feedback; straps flip after latch
    task automatic t_heavy;
        int n;
        @(posedge aclk);
        aresetn <= 1'b0;
        heavy_strap <= 1'b1;
        hall_strap <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        heavy_strap <= 1'b0;
        hall_strap <= 1'b1;
        wr(`DCBS_OFF_LEVEL, 32'h1f4, `DCBS_RESP_OKAY);
        wr(`DCBS_OFF_DELAY, 32'h0, `DCBS_RESP_OKAY);
        wr(`DCBS_OFF_TIME, 32'h1, `DCBS_RESP_OKAY);
        wr(`DCBS_OFF_CTRL, 32'h3, `DCBS_RESP_OKAY);
        `CHK("hall_latched", 1'b0, analog_volt_mode)
        `CHK("overload_heavy", 1'b1, thermal_overload.heavy)
        stop;
        `CHK("freewheel", 1'b1, freewheel_path)
        `CHK("no_short23", 1'b0, short_t2_t3)
        `SPAN(!scr_gate_en, n)
        `CHK("delay0_cycles", 1, n)
        `CHK("extra_start", 1'b1, extra_start)
        `CHK("ref_heavy", 16'h0190, current_ref)
        `SPAN(brake_relay, n)
        `CHK("heavy_cycles", 401 * MSC + 2, n)
        rc(`DCBS_OFF_STARTS, 32'h1, `DCBS_RESP_OKAY, "starts_heavy");
    endtask : t_heavy

    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        end_sim;
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs;
        t_refuse;
        t_sequence;
        t_abort(32'h7, 1'b0);
        t_abort(32'hb, 1'b1);
        t_decay;
        t_heavy;
        end_sim;
    end
endmodule : dcbs_top_tb_top
